// >>> core/port_io_cell_config.sv
`timescale 1ns/1ps
`include "port_io_defines.svh"

// Notes on behaviour
// - after reset all pads float with pull-ups until crossbar enable is set, except the debug pin while the debug line drives it
// - each pin picks analog or digital through its input mode bit
// - analog pins lose driver and receiver, and pull-up once crossbar enable is set; the debug line still drives and reads its pin
// - analog pins always read back zero
// - per-pin output mode bit per port selects push-pull or open-drain
// - push-pull pins drive the pad high or low from the output value
// - open-drain pins drive low on zero and float on one
// - a floating digital pin has its weak pull-up on unless the global pull-up disable bit is set
// - pull-up is off while the pin drives its pad low
// - global pull-up disable bit turns off every pull-up once crossbar enable is set
// - digital pins read back the pad level, not the driven value
// - latch registers read the pad state of digital pins whatever the crossbar does
// - 29 pins: three 8-bit ports and one 5-bit port
// - port 3 bit 0 is shared with the debug data line
// - priority crossbar places enabled peripherals chosen by two select registers
// - crossbar passes over pins whose skip bit is set
module port_io_cell_config
	import port_io_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      rst_n,
	input  wire reg_addr_t reg_addr,
	input  wire reg_data_t reg_wdata,
	input  wire logic      reg_wr,
	input  wire logic      reg_rd,
	output reg_data_t      reg_rdata,
	input  wire pin_vec_t  pad_in,
	output pin_vec_t       pad_out,
	output pin_vec_t       pad_oe,
	output pin_vec_t       pad_pullup,
	input  wire logic      uart_tx_out,
	output logic           uart_rx_in,
	input  wire chan_vec_t periph_out,
	output chan_vec_t      periph_in,
	input  wire logic      debug_data_oe,
	input  wire logic      debug_data_out,
	output logic           debug_data_in
);

	// configuration registers
	reg_data_t latch_reg     [0:3];
	reg_data_t latch_next    [0:3];
	reg_data_t pin_input_mode_reg  [0:3];
	reg_data_t pin_input_mode_next [0:3];
	reg_data_t pin_output_mode_reg  [0:3];
	reg_data_t pin_output_mode_next [0:3];
	reg_data_t pin_skip_reg  [0:2];
	reg_data_t pin_skip_next [0:2];
	reg_data_t crossbar_select_0_reg;
	reg_data_t crossbar_select_0_next;
	reg_data_t crossbar_select_1_reg;
	reg_data_t crossbar_select_1_next;
	reg_data_t rdata_reg;
	reg_data_t rdata_next;

	// pad side state
	pin_vec_t  sync1_reg;
	pin_vec_t  sync2_reg;
	pin_vec_t  out_reg;
	pin_vec_t  out_next;
	pin_vec_t  oe_reg;
	pin_vec_t  oe_next;
	pin_vec_t  pu_reg;
	pin_vec_t  pu_next;
	chan_vec_t pin_to_periph_reg;
	chan_vec_t pin_to_periph_next;
	logic      rx_reg;
	logic      rx_next;
	logic      dbg_in_reg;
	logic      dbg_in_next;

	// flattened views and crossbar results
	pin_vec_t  digital;
	pin_vec_t  push_pull;
	pin_vec_t  latch_flat;
	pin_vec_t  pad_level;
	pin_vec_t  owned;
	chan_idx_t owner [0:28];
	logic [19:0] taken;
	chan_vec_t chan_en;
	chan_vec_t chan_pin_ok;
	logic [4:0] chan_pin [0:12];
	logic      found;
	logic      xbar_on;
	logic      wpud;
	logic      uart_on;

	// select register fields decoded once for the whole block
	assign xbar_on = crossbar_select_1_reg[`XSEL1_CROSSBAR_ENABLE_BIT];
	assign wpud    = crossbar_select_1_reg[`XSEL1_WPUD_BIT];
	assign uart_on = crossbar_select_0_reg[`XSEL0_UART_BIT];
	assign chan_en = {crossbar_select_1_reg[5:0], crossbar_select_0_reg[7:1]};

	// flatten per-port bytes into pin vectors; port 3 keeps only 5 bits
	assign digital    = {pin_input_mode_reg[3][4:0], pin_input_mode_reg[2],
		pin_input_mode_reg[1], pin_input_mode_reg[0]};
	assign push_pull  = {pin_output_mode_reg[3][4:0], pin_output_mode_reg[2],
		pin_output_mode_reg[1], pin_output_mode_reg[0]};
	assign latch_flat = {latch_reg[3][4:0], latch_reg[2], latch_reg[1], latch_reg[0]};
	// receiver disabled on analog pins so they read zero
	assign pad_level  = sync2_reg & digital;

	// priority crossbar: each enabled channel takes the lowest free pin
	always_comb begin
		taken = {pin_skip_reg[2][3:0], pin_skip_reg[1], pin_skip_reg[0]};
		if (uart_on) begin
			// uart pins are fixed, never handed to another channel
			taken[`UART_TX_PIN] = 1'b1;
			taken[`UART_RX_PIN] = 1'b1;
		end
		owned = '0;
		found = 1'b0;
		chan_pin_ok = '0;
		for (int p = 0; p < `NUM_PINS; p++) begin
			owner[p] = '0;
		end
		for (int c = 0; c < `NUM_CHANNELS; c++) begin
			chan_pin[c] = '0;
			found = 1'b0;
			if (chan_en[c]) begin
				for (int p = 0; p < `NUM_XBAR_PINS; p++) begin
					if (!found && !taken[p]) begin
						taken[p] = 1'b1;
						owned[p] = 1'b1;
						owner[p] = 4'(c);
						chan_pin[c] = 5'(p);
						chan_pin_ok[c] = 1'b1;
						found = 1'b1;
					end
				end
			end
		end
	end

	// pad cell behaviour, registered so a config write acts next clock
	always_comb begin
		logic v;
		v = 1'b0;
		out_next = '0;
		oe_next  = '0;
		pu_next  = '0;
		for (int p = 0; p < `NUM_PINS; p++) begin
			if (!xbar_on) begin
				// floating with pull-ups until the crossbar is enabled
				oe_next[p] = 1'b0;
				pu_next[p] = 1'b1;
			end else if (!digital[p]) begin
				oe_next[p] = 1'b0;
				pu_next[p] = 1'b0;
			end else begin
				if (owned[p]) begin
					v = periph_out[owner[p]];
				end else if (uart_on && p == `UART_TX_PIN) begin
					v = uart_tx_out;
				end else begin
					v = latch_flat[p];
				end
				if (push_pull[p]) begin
					out_next[p] = v;
					oe_next[p]  = 1'b1;
				end else begin
					out_next[p] = 1'b0;
					oe_next[p]  = !v;
				end
				// pull-up only while floating, never while sinking
				pu_next[p] = !wpud && !oe_next[p];
			end
		end
		if (debug_data_oe) begin
			// debug line takes over the shared pin
			out_next[`DEBUG_PIN] = debug_data_out;
			oe_next[`DEBUG_PIN]  = 1'b1;
			pu_next[`DEBUG_PIN]  = 1'b0;
		end
		// each channel hears the synced level of the pin it owns
		for (int c = 0; c < `NUM_CHANNELS; c++) begin
			pin_to_periph_next[c] = chan_pin_ok[c] && pad_level[chan_pin[c]];
		end
		rx_next     = uart_on && pad_level[`UART_RX_PIN];
		dbg_in_next = sync2_reg[`DEBUG_PIN];
	end

	// register file: writes and one-cycle read data
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			latch_next[i]           = latch_reg[i];
			pin_input_mode_next[i]  = pin_input_mode_reg[i];
			pin_output_mode_next[i] = pin_output_mode_reg[i];
		end
		for (int i = 0; i < 3; i++) begin
			pin_skip_next[i] = pin_skip_reg[i];
		end
		crossbar_select_0_next = crossbar_select_0_reg;
		crossbar_select_1_next = crossbar_select_1_reg;
		rdata_next = 8'h00;
		// addresses past the map drop writes and read back zero
		if (reg_wr) begin
			if (reg_addr <= `OFS_LATCH3) begin
				latch_next[reg_addr[1:0]] = reg_wdata;
			end else if (reg_addr <= `OFS_MDIN3) begin
				pin_input_mode_next[reg_addr[1:0]] = reg_wdata;
			end else if (reg_addr <= `OFS_MDOUT3) begin
				pin_output_mode_next[reg_addr[1:0]] = reg_wdata;
			end else if (reg_addr <= `OFS_SKIP2) begin
				pin_skip_next[2'(reg_addr - `OFS_SKIP0)] = reg_wdata;
			end else if (reg_addr == `OFS_XSEL0) begin
				crossbar_select_0_next = reg_wdata;
			end else if (reg_addr == `OFS_XSEL1) begin
				crossbar_select_1_next = reg_wdata;
			end
		end
		if (reg_rd) begin
			if (reg_addr <= `OFS_LATCH3) begin
				// latch read shows pad level, not the written value
				unique case (reg_addr[1:0])
					2'b00: rdata_next = pad_level[7:0];
					2'b01: rdata_next = pad_level[15:8];
					2'b10: rdata_next = pad_level[23:16];
					2'b11: rdata_next = {3'b000, pad_level[28:24]};
				endcase
			end else if (reg_addr <= `OFS_MDIN3) begin
				rdata_next = pin_input_mode_reg[reg_addr[1:0]];
			end else if (reg_addr <= `OFS_MDOUT3) begin
				rdata_next = pin_output_mode_reg[reg_addr[1:0]];
			end else if (reg_addr <= `OFS_SKIP2) begin
				rdata_next = pin_skip_reg[2'(reg_addr - `OFS_SKIP0)];
			end else if (reg_addr == `OFS_XSEL0) begin
				rdata_next = crossbar_select_0_reg;
			end else if (reg_addr == `OFS_XSEL1) begin
				rdata_next = crossbar_select_1_reg;
			end
			// port 3 has only five pins, upper bits read zero
			if (reg_addr == `OFS_MDIN3 || reg_addr == `OFS_MDOUT3) begin
				rdata_next = rdata_next & `PORT3_MASK;
			end
		end
	end

	// state registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				latch_reg[i]           <= `RST_LATCH;
				pin_input_mode_reg[i]  <= `RST_MDIN;
				pin_output_mode_reg[i] <= `RST_MDOUT;
			end
			for (int i = 0; i < 3; i++) begin
				pin_skip_reg[i] <= `RST_SKIP;
			end
			crossbar_select_0_reg <= `RST_XSEL;
			crossbar_select_1_reg <= `RST_XSEL;
			rdata_reg         <= 8'h00;
			sync1_reg         <= '0;
			sync2_reg         <= '0;
			out_reg           <= '0;
			oe_reg            <= '0;
			pu_reg            <= '1;
			pin_to_periph_reg <= '0;
			rx_reg            <= 1'b0;
			dbg_in_reg        <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				latch_reg[i]           <= latch_next[i];
				pin_input_mode_reg[i]  <= pin_input_mode_next[i];
				pin_output_mode_reg[i] <= pin_output_mode_next[i];
			end
			for (int i = 0; i < 3; i++) begin
				pin_skip_reg[i] <= pin_skip_next[i];
			end
			crossbar_select_0_reg <= crossbar_select_0_next;
			crossbar_select_1_reg <= crossbar_select_1_next;
			rdata_reg         <= rdata_next;
			// pads are asynchronous, two stages before use
			sync1_reg         <= pad_in;
			sync2_reg         <= sync1_reg;
			out_reg           <= out_next;
			oe_reg            <= oe_next;
			pu_reg            <= pu_next;
			pin_to_periph_reg <= pin_to_periph_next;
			rx_reg            <= rx_next;
			dbg_in_reg        <= dbg_in_next;
		end
	end

	// every output comes from a flop so pads never glitch mid-cycle
	assign reg_rdata     = rdata_reg;
	assign pad_out       = out_reg;
	assign pad_oe        = oe_reg;
	assign pad_pullup    = pu_reg;
	assign periph_in     = pin_to_periph_reg;
	assign uart_rx_in    = rx_reg;
	assign debug_data_in = dbg_in_reg;

endmodule

// >>> core/port_io_defines.svh
`ifndef PORT_IO_DEFINES_SVH
`define PORT_IO_DEFINES_SVH

// pin and channel counts
`define NUM_PINS        29
`define NUM_XBAR_PINS   20
`define NUM_CHANNELS    13
`define PORT3_WIDTH     5

// register offsets, one register per address
`define OFS_LATCH0      5'h00
`define OFS_LATCH3      5'h03
`define OFS_MDIN0       5'h04
`define OFS_MDIN3       5'h07
`define OFS_MDOUT0      5'h08
`define OFS_MDOUT3      5'h0B
`define OFS_SKIP0       5'h0C
`define OFS_SKIP2       5'h0E
`define OFS_XSEL0       5'h0F
`define OFS_XSEL1       5'h10

// field positions
`define XSEL0_UART_BIT  0
`define XSEL1_CROSSBAR_ENABLE_BIT 6
`define XSEL1_WPUD_BIT  7
`define UART_TX_PIN     4
`define UART_RX_PIN     5
`define DEBUG_PIN       24

// reset values and the port 3 read mask
`define RST_LATCH       8'hFF
`define RST_MDIN        8'hFF
`define RST_MDOUT       8'h00
`define RST_SKIP        8'h00
`define RST_XSEL        8'h00
`define PORT3_MASK      8'h1F

`endif

// >>> core/port_io_pkg.sv
package port_io_pkg;
	typedef logic [4:0]  reg_addr_t;
	typedef logic [7:0]  reg_data_t;
	typedef logic [28:0] pin_vec_t;
	typedef logic [12:0] chan_vec_t;
	typedef logic [3:0]  chan_idx_t;
endpackage

// >>> tb/port_io_cell_config_properties.sv
`timescale 1ns/1ps
module port_io_cell_config_properties
	import port_io_pkg::*;
(
	input wire logic      ref_clk,
	input wire logic      rst_n,
	input wire reg_addr_t reg_addr,
	input wire reg_data_t reg_wdata,
	input wire logic      reg_wr,
	input wire logic      reg_rd,
	input wire reg_data_t reg_rdata,
	input wire pin_vec_t  pad_out,
	input wire pin_vec_t  pad_oe,
	input wire pin_vec_t  pad_pullup,
	input wire logic      debug_data_oe,
	input wire logic      debug_data_out
);
	localparam pin_vec_t NO_DBG = 29'h1EFF_FFFF;
	logic      xen_reg, xen_next, wpud_reg, wpud_next;
	reg_data_t mdin_reg, mdin_next;
	// shadow of the config bits the pads follow; port 1 carries the analog tests
	always_comb begin
		xen_next = xen_reg;
		wpud_next = wpud_reg;
		mdin_next = mdin_reg;
		if (reg_wr && reg_addr == 5'h10) begin
			xen_next = reg_wdata[6];
			wpud_next = reg_wdata[7];
		end
		if (reg_wr && reg_addr == 5'h05)
			mdin_next = reg_wdata;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			xen_reg <= 1'b0;
			wpud_reg <= 1'b0;
			mdin_reg <= 8'hFF;
		end else begin
			xen_reg <= xen_next;
			wpud_reg <= wpud_next;
			mdin_reg <= mdin_next;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// pads lag config by one edge, hence the past values
	chk_float_reset: assert property (!$past(xen_reg) |-> (pad_oe & NO_DBG) == '0
		&& (pad_pullup | ~NO_DBG) == '1) else $error("pad active before enable");
	chk_pullup_drive: assert property ((pad_oe & pad_pullup) == '0)
		else $error("pullup on while driving");
	chk_od_low: assert property ((pad_out[15:8] & ~pad_oe[15:8] & $past(mdin_reg)) == 8'h00)
		else $error("released pin shows high drive");
	chk_wpud_all: assert property ($past(xen_reg) && $past(wpud_reg) |-> pad_pullup == '0)
		else $error("pullup left on");
	chk_analog_off: assert property ($past(xen_reg) |->
		((pad_oe[15:8] | pad_pullup[15:8]) & ~$past(mdin_reg)) == 8'h00)
		else $error("analog pin active");
	chk_analog_read: assert property (reg_rd && reg_addr == 5'h01 |=>
		(reg_rdata & ~$past(mdin_reg)) == 8'h00) else $error("analog pin read nonzero");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	chk_unmapped_rd: assert property (reg_rd && reg_addr > 5'h10 |=> reg_rdata == 8'h00)
		else $error("unmapped read nonzero");
	chk_debug_drive: assert property ($past(debug_data_oe) |-> pad_oe[24] && !pad_pullup[24]
		&& pad_out[24] == $past(debug_data_out)) else $error("debug pin not driven");
endmodule
bind port_io_cell_config port_io_cell_config_properties u_port_io_cell_config_properties (.*);

// >>> tb/pad_partner.sv
`timescale 1ns/1ps
module pad_partner
	import port_io_pkg::*;
(
	input  wire logic     ref_clk,
	input  wire pin_vec_t pad_out,
	input  wire pin_vec_t pad_oe,
	input  wire pin_vec_t pad_pullup,
	input  wire pin_vec_t ext_en,
	input  wire pin_vec_t ext_val,
	output pin_vec_t      pad_in
);
	pin_vec_t wobble = '0;
	// an unpulled, undriven pad wanders so no stale level passes
	always @(posedge ref_clk)
		wobble <= ~wobble;
	// board drives only pins the cell released
	always_comb
		for (int i = 0; i < 29; i++)
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
				pad_pullup[i] ? 1'b1 : wobble[i];
endmodule

// >>> tb/port_io_cell_config_tb.sv
`timescale 1ns/1ps
module port_io_cell_config_tb
	import port_io_pkg::*;
;
	logic      ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic      uart_tx_out = 0, uart_rx_in, dbg_oe = 0, dbg_out = 0, dbg_in;
	reg_addr_t reg_addr = '0;
	reg_data_t reg_wdata = '0, reg_rdata;
	pin_vec_t  pad_in, pad_out, pad_oe, pad_pullup, ext_en = '0, ext_val = '0;
	chan_vec_t periph_out = '0, periph_in;
	int        miscompares = 0, samples_checked = 0;
	always #50 ref_clk = ~ref_clk;
	port_io_cell_config u_port_io_cell_config (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pullup), .uart_tx_out(uart_tx_out), .uart_rx_in(uart_rx_in),
		.periph_out(periph_out), .periph_in(periph_in), .debug_data_oe(dbg_oe),
		.debug_data_out(dbg_out), .debug_data_in(dbg_in));
	pad_partner u_pad_partner (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	task automatic cmp_pad(input pin_vec_t got, input pin_vec_t exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t pads %h expected %h", $time, got, exp);
		end
	endtask
	// register read, data taken in the one cycle it stands
	task automatic rd_cmp(input reg_addr_t a, input reg_data_t exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		samples_checked++;
		if (reg_rdata !== exp) begin
			miscompares++;
			$display("ERROR %0t reg %h read %h expected %h", $time, a, reg_rdata, exp);
		end
	endtask
	// returns one edge after the write, when pads have followed
	task automatic wr(input reg_addr_t a, input reg_data_t d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard
	initial begin
		#200000;
		miscompares++;
		give_verdict;
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		cmp_pad(pad_oe, '0);
		cmp_pad(pad_pullup, '1);
		rd_cmp(5'h00, 8'hFF);
		rd_cmp(5'h03, 8'h1F);
		rd_cmp(5'h04, 8'hFF);
		rd_cmp(5'h08, 8'h00);
		wr(5'h11, 8'h5A);
		rd_cmp(5'h11, 8'h00);
		wr(5'h00, 8'h00);
		cmp_pad(pad_oe, '0);
		$display("test reset done");
		wr(5'h10, 8'h40);
		cmp_pad(pad_oe, 29'h0000_00FF);
		cmp_pad(pad_out, '0);
		cmp_pad(pad_pullup, 29'h1FFF_FF00);
		$display("test open drain done");
		ext_en <= 29'h0000_FF00;
		ext_val <= 29'h0000_3C00;
		wr(5'h08, 8'hFF);
		wr(5'h00, 8'hA5);
		cmp_pad(pad_out, 29'h0000_00A5);
		cmp_pad(pad_oe, 29'h0000_00FF);
		// new pad level needs both sync stages before a read strobe sees it
		@(posedge ref_clk);
		rd_cmp(5'h00, 8'hA5);
		rd_cmp(5'h01, 8'h3C);
		$display("test push pull done");
		wr(5'h05, 8'h0F);
		rd_cmp(5'h01, 8'h0C);
		cmp_pad(pad_pullup, 29'h1FFF_0F00);
		$display("test analog done");
		@(posedge ref_clk);
		periph_out <= 13'h0001;
		wr(5'h0C, 8'h01);
		wr(5'h0F, 8'h02);
		cmp_pad(pad_out, 29'h0000_00A7);
		// pad level reaches the channel after two sync stages and its flop
		repeat (3) @(posedge ref_clk);
		#1;
		cmp_pad(pin_vec_t'(periph_in), 29'h0000_0001);
		@(posedge ref_clk);
		periph_out <= 13'h0000;
		wr(5'h0C, 8'h03);
		cmp_pad(pad_out, 29'h0000_00A1);
		$display("test crossbar done");
		@(posedge ref_clk);
		dbg_oe <= 1'b1;
		dbg_out <= 1'b0;
		@(posedge ref_clk);
		#1;
		cmp_pad(pad_oe, 29'h0100_00FF);
		cmp_pad(pad_out, 29'h0000_00A1);
		// driven low pin comes back through the two sync stages
		repeat (3) @(posedge ref_clk);
		#1;
		cmp_pad(pin_vec_t'(dbg_in), 29'h0000_0000);
		wr(5'h10, 8'hC0);
		cmp_pad(pad_pullup, '0);
		$display("test debug and pullup done");
		@(posedge ref_clk);
		uart_tx_out <= 1'b1;
		wr(5'h0F, 8'h03);
		cmp_pad(pad_out, 29'h0000_00B1);
		cmp_pad(pin_vec_t'(uart_rx_in), 29'h0000_0001);
		$display("test uart done");
		give_verdict;
	end
endmodule
